// ===== socket_event_defs.svh
// constants for the socket event and mask block
// assumes inclusion by bare name from the top module
`ifndef SOCKET_EVENT_DEFS_SVH
`define SOCKET_EVENT_DEFS_SVH

`define CFG_BAR_OFFSET 8'h10
`define BAR_WINDOW_BITS 12
`define BAR_RESET 20'h00000
`define FLAGS_OFFSET 10'h000
`define IRQ_ENABLE_OFFSET 10'h001
`define POWER_CYCLE_BIT 3
`define CARD_DETECT_TWO_BIT 2
`define CARD_DETECT_ONE_BIT 1
`define STATUS_CHANGE_BIT 0
`define FLAGS_RESET 4'h0
`define IRQ_ENABLE_RESET 4'h0
`define IMPL_BITS 4
`define READ_ZERO 32'h00000000

`endif

// ===== socket_event_pkg.sv
// types shared by the socket event block and its surroundings
// assumes socket_event_defs.svh holds the numeric constants
package socket_event_pkg;

  // one bit per tracked socket condition, in event bit order
  typedef struct packed {
    logic power_cycle;
    logic card_detect_two;
    logic card_detect_one;
    logic card_status;
  } socket_status_t;

  // memory-space access as seen before the target's own decode
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } mem_access_t;

  // configuration-space access
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_access_t;

endpackage

// ===== cardbus_socket_event_mask.sv
// socket status-change flags, interrupt enables and the card status change interrupt
// assumes socket status, force strobes and card reset come synchronous to the pci clock
`timescale 1ns/1ps
`include "socket_event_defs.svh"

// Behaviour
// - socket register set is five 32-bit registers; this block holds flags and enables.
// - registers live in memory space at a base from config offset 10h, per socket.
// - flag register answers at byte offset 00h from the socket base.
// - enable register answers at byte offset 04h from the socket base.
// - writing one clears a flag; writing zero leaves it.
// - writing one to the force-event bit sets the matching flag.
// - bus reset clears all flags.
// - leaving card reset sets the status-change and card-detect flags again at once if their inputs are high; power-cycle is not set.
// - interrupt is raised while any flag is set and enabled.
// - bits 31 to 4 of both registers read zero and ignore writes.
// - flag bit 3 sets when the power-cycle state changes.
// - flag bits 2 and 1 set when card-detect two or one changes.
// - with a CardBus card, flag bit 0 sets only on status-change rising edge.
// - with a 16-bit card, flag bit 0 sets on both status-change edges.
// - enables gate only the interrupt; flags latch regardless.
// - enable bit 3 lets a power-cycle flag interrupt; zero blocks it.
// - card-detect enable 11 lets detect flags interrupt; 00 blocks; 01 and 10 undefined.
// - enable bit 0 lets a status-change flag interrupt; reset value zero blocks it.
module cardbus_socket_event_mask #(
  parameter int FLAG_BITS = `IMPL_BITS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire socket_event_pkg::cfg_access_t cfg_access,
  output logic [31:0] cfg_rdata,
  input wire socket_event_pkg::mem_access_t mem_access,
  output logic mem_claim,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  input wire socket_event_pkg::socket_status_t socket_status,
  input wire logic cardbus_card,
  input wire logic card_in_reset,
  input wire logic force_event_write,
  input wire logic [FLAG_BITS-1:0] force_event_data,
  output logic card_status_change_interrupt
);

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // base address register
  logic [31-`BAR_WINDOW_BITS:0] bar_base_reg;
  logic [31-`BAR_WINDOW_BITS:0] bar_base_next;
  logic cfg_bar_sel;
  logic cfg_bar_write;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] cfg_rdata_next;

  assign cfg_bar_sel = cfg_access.valid && (cfg_access.offset == `CFG_BAR_OFFSET);
  assign cfg_bar_write = cfg_bar_sel && cfg_access.write;
  // byte lanes 1 to 3 carry the base; lane 0 holds only fixed low bits
  assign bar_base_next = {
    cfg_access.byte_en[3] ? cfg_access.wdata[31:24] : bar_base_reg[19:12],
    cfg_access.byte_en[2] ? cfg_access.wdata[23:16] : bar_base_reg[11:4],
    cfg_access.byte_en[1] ? cfg_access.wdata[15:12] : bar_base_reg[3:0]
  };
  assign cfg_rdata_next = (cfg_bar_sel && !cfg_access.write) ?
    {bar_base_reg, {`BAR_WINDOW_BITS{1'b0}}} : `READ_ZERO;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bar_base_reg <= `BAR_RESET;
      cfg_rdata_reg <= `READ_ZERO;
    end
    else
    begin
      if (cfg_bar_write)
        bar_base_reg <= bar_base_next;
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;

  // memory decode: word index inside the socket window
  logic mem_hit;
  logic [9:0] word_index;
  logic flags_sel;
  logic enable_sel;
  logic flags_write;
  logic enable_write;

  assign mem_hit = mem_access.valid && (mem_access.addr[31:`BAR_WINDOW_BITS] == bar_base_reg);
  assign word_index = mem_access.addr[`BAR_WINDOW_BITS-1:2];
  assign flags_sel = mem_hit && (word_index == `FLAGS_OFFSET);
  assign enable_sel = mem_hit && (word_index == `IRQ_ENABLE_OFFSET);
  // implemented bits all sit in byte lane 0; upper lanes are ignored
  assign flags_write = flags_sel && mem_access.write && mem_access.byte_en[0];
  assign enable_write = enable_sel && mem_access.write && mem_access.byte_en[0];
  assign mem_claim = mem_hit;

  // change detection against the previous sample
  socket_event_pkg::socket_status_t status_prev_reg;
  logic primed_reg;
  logic card_in_reset_prev_reg;
  logic [FLAG_BITS-1:0] status_now;
  logic [FLAG_BITS-1:0] status_prev;
  logic [FLAG_BITS-1:0] status_rise;
  logic [FLAG_BITS-1:0] status_changed;
  logic reset_exit;
  logic [FLAG_BITS-1:0] hw_set;
  logic [FLAG_BITS-1:0] force_set;
  logic [FLAG_BITS-1:0] soft_clear;
  logic [FLAG_BITS-1:0] flags_reg;
  logic [FLAG_BITS-1:0] flags_next;

  assign status_now = socket_status;
  assign status_prev = status_prev_reg;

  // first sample after reset only primes the history, so a high input is no false change
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_BITS; gi++)
    begin : g_detect
      assign status_changed[gi] = primed_reg && (status_now[gi] != status_prev[gi]);
      assign status_rise[gi] = primed_reg && status_now[gi] && !status_prev[gi];
    end
  endgenerate

  assign reset_exit = card_in_reset_prev_reg && !card_in_reset;

  always_comb
  begin
    hw_set = '0;
    hw_set[`POWER_CYCLE_BIT] = status_changed[`POWER_CYCLE_BIT];
    hw_set[`CARD_DETECT_TWO_BIT] = status_changed[`CARD_DETECT_TWO_BIT];
    hw_set[`CARD_DETECT_ONE_BIT] = status_changed[`CARD_DETECT_ONE_BIT];
    hw_set[`STATUS_CHANGE_BIT] = cardbus_card ? status_rise[`STATUS_CHANGE_BIT]
                                              : status_changed[`STATUS_CHANGE_BIT];
    if (reset_exit)
    begin
      // a status-change or card-detect condition still present when card reset ends is reported again
      hw_set[`STATUS_CHANGE_BIT] = hw_set[`STATUS_CHANGE_BIT] || socket_status.card_status;
      hw_set[`CARD_DETECT_ONE_BIT] = hw_set[`CARD_DETECT_ONE_BIT] || socket_status.card_detect_one;
      hw_set[`CARD_DETECT_TWO_BIT] = hw_set[`CARD_DETECT_TWO_BIT] || socket_status.card_detect_two;
    end
  end

  assign force_set = force_event_write ? force_event_data : '0;
  assign soft_clear = flags_write ? mem_access.wdata[FLAG_BITS-1:0] : '0;
  // set beats clear so an event in the clearing cycle is kept
  assign flags_next = (flags_reg & ~soft_clear) | hw_set | force_set;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg <= `FLAGS_RESET;
      status_prev_reg <= '0;
      primed_reg <= 1'b0;
      card_in_reset_prev_reg <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      status_prev_reg <= socket_status;
      primed_reg <= 1'b1;
      card_in_reset_prev_reg <= card_in_reset;
    end
  end

  // interrupt enables
  logic [FLAG_BITS-1:0] irq_enable_reg;
  logic [FLAG_BITS-1:0] irq_gate;
  logic card_detect_enabled;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    else if (enable_write)
      irq_enable_reg <= mem_access.wdata[FLAG_BITS-1:0];
  end

  // the undefined detect codes 01 and 10 are treated as blocking
  assign card_detect_enabled = irq_enable_reg[`CARD_DETECT_TWO_BIT] && irq_enable_reg[`CARD_DETECT_ONE_BIT];

  always_comb
  begin
    irq_gate = '0;
    irq_gate[`POWER_CYCLE_BIT] = irq_enable_reg[`POWER_CYCLE_BIT];
    irq_gate[`CARD_DETECT_TWO_BIT] = card_detect_enabled;
    irq_gate[`CARD_DETECT_ONE_BIT] = card_detect_enabled;
    irq_gate[`STATUS_CHANGE_BIT] = irq_enable_reg[`STATUS_CHANGE_BIT];
  end

  // level output straight from flags; leftover flags fire as soon as enabled
  assign card_status_change_interrupt = |(flags_reg & irq_gate);

  // read data and acknowledge, one cycle after the access
  logic [31:0] mem_rdata_reg;
  logic [31:0] mem_rdata_next;
  logic mem_ack_reg;

  assign mem_rdata_next = (flags_sel && !mem_access.write) ? {{(32-FLAG_BITS){1'b0}}, flags_reg} :
                          (enable_sel && !mem_access.write) ? {{(32-FLAG_BITS){1'b0}}, irq_enable_reg} :
                          `READ_ZERO;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rdata_reg <= `READ_ZERO;
      mem_ack_reg <= 1'b0;
    end
    else
    begin
      mem_rdata_reg <= mem_rdata_next;
      mem_ack_reg <= mem_hit;
    end
  end

  assign mem_rdata = mem_rdata_reg;
  assign mem_ack = mem_ack_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_clear_by_one: assert property (
    (flags_write && mem_access.wdata[0] && !hw_set[0] && !force_set[0]) |=> !flags_reg[0])
    else $error("flag 0 not cleared by write of one");
  chk_zero_keeps_flag: assert property (
    (flags_write && !mem_access.wdata[3] && flags_reg[3]) |=> flags_reg[3])
    else $error("flag 3 lost on write of zero");
  chk_force_sets_flag: assert property (
    (force_event_write && force_event_data[2]) |=> flags_reg[2])
    else $error("force write did not set flag 2");
  chk_set_beats_clear: assert property (
    (flags_write && mem_access.wdata[3] && primed_reg && $changed(socket_status.power_cycle)) |=> flags_reg[3])
    else $error("power-cycle event lost under clear");
  chk_power_change: assert property (
    (primed_reg && (socket_status.power_cycle != status_prev_reg.power_cycle)) |=> flags_reg[3])
    else $error("power-cycle change not latched");
  chk_cardbus_fall_ignored: assert property (
    (cardbus_card && !flags_reg[0] && !force_set[0] && !reset_exit && primed_reg
     && !socket_status.card_status && status_prev_reg.card_status) |=> !flags_reg[0])
    else $error("falling edge set flag 0 for cardbus card");
  chk_sixteen_bit_fall: assert property (
    (!cardbus_card && primed_reg && !socket_status.card_status && status_prev_reg.card_status) |=> flags_reg[0])
    else $error("falling edge missed for 16-bit card");
  chk_irq_masked_detect: assert property (
    (irq_enable_reg[2:1] != 2'b11 && flags_reg[0] == 1'b0 && flags_reg[3] == 1'b0) |-> !card_status_change_interrupt)
    else $error("blocked detect flags raised interrupt");
  chk_irq_follows_flag: assert property (
    (force_event_write && force_event_data[3] && irq_enable_reg[3] && !enable_write) |=> card_status_change_interrupt)
    else $error("enabled flag did not interrupt");
  chk_reset_exit_detect: assert property (
    (reset_exit && socket_status.card_detect_one) |=> flags_reg[1])
    else $error("detect flag not set on leaving card reset");
  chk_read_reserved: assert property (
    (flags_sel && !mem_access.write) |=> (mem_ack && mem_rdata[31:4] == 28'h0000000))
    else $error("reserved flag bits read nonzero");
  chk_enable_reserved: assert property (
    (enable_sel && !mem_access.write) |=> (mem_ack && mem_rdata[31:4] == 28'h0000000))
    else $error("reserved enable bits read nonzero");
  chk_power_irq_gate: assert property (
    (flags_reg[3] && irq_enable_reg[3]) |-> card_status_change_interrupt)
    else $error("enabled power-cycle flag did not interrupt");
  chk_detect_irq_gate: assert property (
    (flags_reg[1] && irq_enable_reg[2:1] == 2'b11) |-> card_status_change_interrupt)
    else $error("enabled detect flag did not interrupt");
  chk_status_irq_gate: assert property (
    (flags_reg[0] && irq_enable_reg[0]) |-> card_status_change_interrupt)
    else $error("enabled status-change flag did not interrupt");
  chk_ack_after_claim: assert property (
    mem_claim |=> mem_ack)
    else $error("claimed access not acknowledged");

  cov_force_then_clear: cover property (force_event_write ##[1:8] flags_write);
  cov_detect_irq: cover property (card_detect_enabled && flags_reg[1] && card_status_change_interrupt);
  cov_reset_exit: cover property (reset_exit && socket_status.card_status);
  cov_sixteen_bit_edge: cover property (!cardbus_card && primed_reg && $fell(socket_status.card_status));
  cov_set_beats_clear: cover property (flags_write && mem_access.wdata[3] && hw_set[3]);

endmodule

// ===== host_bus_model.sv
// host bus master model: config and memory accesses toward the socket block
// assumes one rising-edge clock shared with the block
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  output socket_event_pkg::cfg_access_t cfg_access,
  output socket_event_pkg::mem_access_t mem_access
);
  logic last_read;
  initial
  begin
    cfg_access = '0;
    mem_access = '0;
    last_read = 1'b0;
  end
  // released lines show the inverse, so a design reading them while idle is caught
  task automatic cfg_op(input logic wr, input logic [7:0] off, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfg_access = {1'b1, wr, off, 4'hF, d};
    @(posedge clk);
    #1;
    cfg_access = {1'b0, ~cfg_access[44:0]};
  endtask
  task automatic mem_op(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    last_read = ~wr;
    mem_access = {1'b1, wr, a, 4'hF, d};
    @(posedge clk);
    #1;
    mem_access = {1'b0, ~mem_access[68:0]};
  endtask
endmodule

// ===== cardbus_socket_event_mask_tb.sv
// self-checking bench for the socket event flags, enables and interrupt
// assumes host_bus_model drives both request buses
`timescale 1ns/1ps
module cardbus_socket_event_mask_tb;
  localparam logic [31:0] BASE = 32'hA0000000;
  logic clk, reset_n, mem_claim, mem_ack, irq;
  logic cardbus_card, card_in_reset, force_event_write;
  logic [3:0] fv;
  logic [31:0] cfg_rdata, mem_rdata;
  socket_event_pkg::cfg_access_t cfg_access;
  socket_event_pkg::mem_access_t mem_access;
  socket_event_pkg::socket_status_t st;
  logic [31:0] exp_q[$];
  int n_errors, cmp_count, cycles;
  host_bus_model u_host (.clk(clk), .cfg_access(cfg_access), .mem_access(mem_access));
  cardbus_socket_event_mask u_dut (.clk(clk), .reset_n(reset_n), .cfg_access(cfg_access),
    .cfg_rdata(cfg_rdata), .mem_access(mem_access), .mem_claim(mem_claim), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .socket_status(st), .cardbus_card(cardbus_card),
    .card_in_reset(card_in_reset), .force_event_write(force_event_write),
    .force_event_data(fv), .card_status_change_interrupt(irq));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [31:0] off, input logic [31:0] exp);
    exp_q.push_back(exp);
    u_host.mem_op(1'b0, BASE + off, 32'h0);
  endtask
  task automatic wr(input logic [31:0] off, input logic [31:0] d);
    u_host.mem_op(1'b1, BASE + off, d);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, irq}, {31'h0, e});
  endtask
  task automatic do_reset(input int n);
    reset_n = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    u_host.cfg_op(1'b1, 8'h10, BASE | 32'h00000FFF);
  endtask
  // ack for a read pops the oldest note; an ack with nothing pending is a stray claim
  always @(negedge clk)
    if (mem_ack === 1'b1 && u_host.last_read === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(32'hDEAD0000, 32'h0);
      else
        check(mem_rdata, exp_q.pop_front());
    end
  // claim is combinational and stands only in the request cycle, so look mid-cycle
  always @(negedge clk)
    if (mem_access.valid === 1'b1)
      check({31'h0, mem_claim}, {31'h0, mem_access.addr[31:12] == BASE[31:12]});
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    st = '0;
    cardbus_card = 1'b0;
    card_in_reset = 1'b0;
    force_event_write = 1'b0;
    fv = 4'h0;
    void'($urandom(32'hBA517215));
    do_reset(8);
    u_host.cfg_op(1'b0, 8'h10, 32'h0);
    check(cfg_rdata, BASE);
    u_host.cfg_op(1'b0, 8'h14, 32'h0);
    check(cfg_rdata, 32'h0);
    rd(0, 0);
    rd(4, 0);
    wr(0, 32'h0000000F);
    wr(4, 32'hFFFFFFFF);
    rd(4, 32'h0000000F);
    wr(0, 32'hFFFFFFF0);
    rd(0, 0);
    wr(4, 0);
    st.power_cycle = 1'b1;
    irq_is(1'b0);
    rd(0, 32'h8);
    wr(4, 32'h8);
    irq_is(1'b1);
    wr(0, 0);
    rd(0, 32'h8);
    wr(0, 32'h8);
    rd(0, 0);
    irq_is(1'b0);
    st.card_detect_one = 1'b1;
    rd(0, 32'h2);
    st.card_detect_two = 1'b1;
    rd(0, 32'h6);
    wr(4, 32'h2);
    irq_is(1'b0);
    wr(4, 32'h6);
    irq_is(1'b1);
    wr(0, 32'h6);
    wr(4, 0);
    cardbus_card = 1'b1;
    st.card_status = 1'b1;
    rd(0, 32'h1);
    wr(0, 32'h1);
    st.card_status = 1'b0;
    rd(0, 0);
    cardbus_card = 1'b0;
    st.card_status = 1'b1;
    rd(0, 32'h1);
    wr(0, 32'h1);
    st.card_status = 1'b0;
    rd(0, 32'h1);
    wr(4, 32'h1);
    irq_is(1'b1);
    wr(0, 32'h1);
    irq_is(1'b0);
    wr(4, 0);
    repeat (4)
    begin
      @(posedge clk);
      #1;
      fv = 4'($urandom);
      force_event_write = 1'b1;
      @(posedge clk);
      #1;
      force_event_write = 1'b0;
      rd(0, {28'h0, fv});
      wr(0, 32'hF);
    end
    wr(4, 32'h8);
    fork
      wr(0, 32'h8);
      begin
        @(posedge clk);
        #1;
        fv = 4'h8;
        force_event_write = 1'b1;
        @(posedge clk);
        #1;
        force_event_write = 1'b0;
      end
    join
    rd(0, 32'h8);
    irq_is(1'b1);
    fork
      wr(0, 32'h8);
      begin
        @(posedge clk);
        #1;
        st.power_cycle = ~st.power_cycle;
      end
    join
    rd(0, 32'h8);
    st.card_status = 1'b1;
    card_in_reset = 1'b1;
    wr(0, 32'hF);
    rd(0, 0);
    card_in_reset = 1'b0;
    rd(0, 32'h7);
    rd(32'hFFC, 0);
    u_host.mem_op(1'b0, 32'hB0000000, 32'h0);
    #3;
    do_reset(2);
    rd(0, 0);
    rd(4, 0);
    repeat (4) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule
